// >>> bsf_host.sv
// bsf_host: host-side controller that runs flash command sequences on device pins
// assumes flash pins are asynchronous to clk; data inputs and ready_busy_n are synchronised here
`timescale 1ns/1ns
// How it works
// - commands are plain bus write cycles
// - bypass mode programs in two writes
// - completion via ready_busy_n, then a steady toggle bit
// - erase pause and resume commands offered
// - host idles chip select for standby
// - output strobe only during reads, no contention
module bsf_host import bsf_pkg::*; #(
  parameter int TIMEOUT_CYC = 100000000
) (
  input wire logic clk,
  input wire logic resetn,
  input wire bsf_req_t req,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic word_mode,
  input wire logic abort,
  output bsf_rsp_t rsp,
  output bsf_pins_t pins,
  input wire logic [BSF_DATA_W-1:0] data_lines_in,
  input wire logic ready_busy_n
);
  typedef enum {S_IDLE, S_SETUP, S_STROBE, S_GAP, S_READ, S_RSAMP, S_WAIT, S_POLL, S_POLL2, S_DONE} bsf_state_t;

  bsf_state_t state_r, state_nxt;
  bsf_req_t cur_r, cur_nxt;
  logic [2:0] step_r, step_nxt;
  logic [2:0] nstep_r, nstep_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [31:0] tmo_r, tmo_nxt;
  logic bypass_r, bypass_nxt;
  logic wait_r, wait_nxt;
  logic [BSF_DATA_W-1:0] tog_r, tog_nxt;
  bsf_pins_t pins_r, pins_nxt;
  bsf_rsp_t rsp_r, rsp_nxt;
  logic [BSF_DATA_W-1:0] din_s1_r, din_s2_r;
  logic rb_s1_r, rb_s2_r;

  // one write cycle of a command sequence: address and data of step k
  function automatic logic [BSF_ADDR_W+BSF_DATA_W-1:0] seq_word(input bsf_req_t r, input logic [2:0] k,
                                                                 input logic byp);
    logic [BSF_ADDR_W-1:0] a;
    logic [BSF_DATA_W-1:0] d;
    a = BSF_ADDR_W'(BSF_UNLOCK1_ADDR);
    d = BSF_UNLOCK1_DATA;
    if (k == 3'h1 || k == 3'h4) begin
      a = BSF_ADDR_W'(BSF_UNLOCK2_ADDR);
      d = BSF_UNLOCK2_DATA;
    end
    unique case (r.op)
      BSF_OP_PROG: begin
        if (byp) begin
          d = (k == 3'h0) ? BSF_CMD_PROG : r.data;
          if (k == 3'h1) a = r.addr;
        end else if (k == 3'h2) d = BSF_CMD_PROG;
        else if (k == 3'h3) begin
          a = r.addr;
          d = r.data;
        end
      end
      BSF_OP_CHIP_ERASE, BSF_OP_SECT_ERASE: begin
        if (k == 3'h2) d = BSF_CMD_ERASE;
        else if (k == 3'h3) d = BSF_UNLOCK1_DATA;
        else if (k == 3'h5) begin
          d = (r.op == BSF_OP_CHIP_ERASE) ? BSF_CMD_CHIP : BSF_CMD_SECTOR;
          if (r.op == BSF_OP_SECT_ERASE) a = r.addr;
        end
      end
      BSF_OP_BYPASS_ENTER: if (k == 3'h2) d = BSF_CMD_BYPASS;
      BSF_OP_BYPASS_EXIT: d = (k == 3'h0) ? BSF_CMD_BYPASS_EXIT1 : BSF_CMD_BYPASS_EXIT2;
      BSF_OP_PAUSE: d = BSF_CMD_PAUSE;
      BSF_OP_RESUME: d = BSF_CMD_RESUME;
      BSF_OP_RESET: d = BSF_CMD_RESET;
      BSF_OP_RAW: begin
        a = r.addr;
        d = r.data;
      end
      default: begin
        a = r.addr;
        d = r.data;
      end
    endcase
    if (!word_mode) d[15:8] = 8'h00;
    return {a, d};
  endfunction : seq_word

  function automatic logic [2:0] seq_len(input logic [3:0] op, input logic byp);
    logic [2:0] n;
    n = 3'h1;
    unique case (op)
      BSF_OP_PROG: n = byp ? 3'h2 : 3'h4;
      BSF_OP_CHIP_ERASE, BSF_OP_SECT_ERASE: n = 3'h6;
      BSF_OP_BYPASS_ENTER: n = 3'h3;
      BSF_OP_BYPASS_EXIT: n = 3'h2;
      default: n = 3'h1;
    endcase
    return n;
  endfunction : seq_len

  always_comb begin
    logic [BSF_ADDR_W+BSF_DATA_W-1:0] w;
    w = seq_word(cur_r, step_r, bypass_r);
    state_nxt = state_r;
    cur_nxt = cur_r;
    step_nxt = step_r;
    nstep_nxt = nstep_r;
    cnt_nxt = cnt_r;
    tmo_nxt = tmo_r;
    bypass_nxt = bypass_r;
    wait_nxt = wait_r;
    tog_nxt = tog_r;
    pins_nxt = pins_r;
    rsp_nxt = rsp_r;
    rsp_nxt.done = 1'b0;
    pins_nxt.restart_n = ~abort;
    pins_nxt.byte_mode_n = word_mode;
    unique case (state_r)
      S_IDLE: begin
        pins_nxt.chip_sel_n = 1'b1;
        pins_nxt.write_strobe_n = 1'b1;
        pins_nxt.out_strobe_n = 1'b1;
        pins_nxt.doe = '0;
        if (req_valid) begin
          cur_nxt = req;
          step_nxt = 3'h0;
          nstep_nxt = seq_len(req.op, bypass_r);
          cnt_nxt = BSF_STROBE_CNT;
          rsp_nxt.busy = 1'b1;
          rsp_nxt.timed_out = 1'b0;
          wait_nxt = (req.op == BSF_OP_PROG) || (req.op == BSF_OP_CHIP_ERASE) || (req.op == BSF_OP_SECT_ERASE)
                     || (req.op == BSF_OP_RESUME);
          if (req.op == BSF_OP_READ) begin
            pins_nxt.addr = req.addr;
            pins_nxt.chip_sel_n = 1'b0;
            pins_nxt.out_strobe_n = 1'b0;
            state_nxt = S_READ;
          end else state_nxt = S_SETUP;
        end
      end
      S_SETUP: begin
        pins_nxt.addr = w[BSF_ADDR_W+BSF_DATA_W-1:BSF_DATA_W];
        pins_nxt.dout = w[BSF_DATA_W-1:0];
        pins_nxt.doe = word_mode ? 16'hffff : 16'h00ff;
        pins_nxt.chip_sel_n = 1'b0;
        pins_nxt.write_strobe_n = 1'b0;
        state_nxt = S_STROBE;
      end
      S_STROBE: begin
        cnt_nxt = cnt_r - 4'h1;
        if (cnt_r == 4'h1) begin
          pins_nxt.write_strobe_n = 1'b1;
          state_nxt = S_GAP;
        end
      end
      S_GAP: begin
        pins_nxt.chip_sel_n = 1'b1;
        pins_nxt.doe = '0;
        cnt_nxt = BSF_STROBE_CNT;
        step_nxt = step_r + 3'h1;
        if (step_r + 3'h1 != nstep_r) state_nxt = S_SETUP;
        else begin
          if (cur_r.op == BSF_OP_BYPASS_ENTER) bypass_nxt = 1'b1;
          if (cur_r.op == BSF_OP_BYPASS_EXIT || cur_r.op == BSF_OP_RESET) bypass_nxt = 1'b0;
          tmo_nxt = '0;
          state_nxt = wait_r ? S_WAIT : S_DONE;
        end
      end
      S_READ: begin
        cnt_nxt = cnt_r - 4'h1;
        if (cnt_r == 4'h1) state_nxt = S_RSAMP;
      end
      S_RSAMP: begin
        // two cycles of synchroniser latency are covered by the strobe count being long
        rsp_nxt.rdata = word_mode ? din_s2_r : {8'h00, din_s2_r[7:0]};
        pins_nxt.out_strobe_n = 1'b1;
        pins_nxt.chip_sel_n = 1'b1;
        state_nxt = S_DONE;
      end
      S_WAIT: begin
        tmo_nxt = tmo_r + 32'h1;
        if (tmo_r >= 32'(TIMEOUT_CYC)) begin
          rsp_nxt.timed_out = 1'b1;
          state_nxt = S_DONE;
        end else if (tmo_r > 32'h4 && rb_s2_r) begin
          pins_nxt.addr = cur_r.addr;
          pins_nxt.chip_sel_n = 1'b0;
          pins_nxt.out_strobe_n = 1'b0;
          cnt_nxt = BSF_STROBE_CNT;
          state_nxt = S_POLL;
        end
      end
      S_POLL: begin
        cnt_nxt = cnt_r - 4'h1;
        if (cnt_r == 4'h1) begin
          tog_nxt = din_s2_r;
          pins_nxt.out_strobe_n = 1'b1;
          cnt_nxt = BSF_STROBE_CNT;
          state_nxt = S_POLL2;
        end
      end
      S_POLL2: begin
        cnt_nxt = cnt_r - 4'h1;
        if (cnt_r == BSF_STROBE_CNT) pins_nxt.out_strobe_n = 1'b0;
        else if (cnt_r == 4'h1) begin
          pins_nxt.out_strobe_n = 1'b1;
          pins_nxt.chip_sel_n = 1'b1;
          // toggle bit steady means the device is back in array read
          if (din_s2_r[BSF_TOGGLE_BIT] == tog_r[BSF_TOGGLE_BIT]) state_nxt = S_DONE;
          else state_nxt = S_WAIT;
        end
      end
      S_DONE: begin
        rsp_nxt.busy = 1'b0;
        rsp_nxt.done = 1'b1;
        state_nxt = S_IDLE;
      end
    endcase
    if (abort) begin
      state_nxt = S_IDLE;
      bypass_nxt = 1'b0;
      rsp_nxt.busy = 1'b0;
      pins_nxt.chip_sel_n = 1'b1;
      pins_nxt.write_strobe_n = 1'b1;
      pins_nxt.out_strobe_n = 1'b1;
      pins_nxt.doe = '0;
    end
  end

  always_ff @(posedge clk) begin
    din_s1_r <= data_lines_in;
    din_s2_r <= din_s1_r;
    rb_s1_r <= ready_busy_n;
    rb_s2_r <= rb_s1_r;
    if (!resetn) begin
      state_r <= S_IDLE;
      cur_r <= '0;
      step_r <= 3'h0;
      nstep_r <= 3'h1;
      cnt_r <= 4'h0;
      tmo_r <= '0;
      bypass_r <= 1'b0;
      wait_r <= 1'b0;
      tog_r <= '0;
      pins_r <= '{addr: '0, dout: '0, doe: '0, chip_sel_n: 1'b1, write_strobe_n: 1'b1,
                  out_strobe_n: 1'b1, restart_n: 1'b0, byte_mode_n: 1'b1};
      rsp_r <= '0;
    end else begin
      state_r <= state_nxt;
      cur_r <= cur_nxt;
      step_r <= step_nxt;
      nstep_r <= nstep_nxt;
      cnt_r <= cnt_nxt;
      tmo_r <= tmo_nxt;
      bypass_r <= bypass_nxt;
      wait_r <= wait_nxt;
      tog_r <= tog_nxt;
      pins_r <= pins_nxt;
      rsp_r <= rsp_nxt;
    end
  end

  assign req_ready = (state_r == S_IDLE) && !abort;
  assign pins = pins_r;
  assign rsp = rsp_r;
endmodule : bsf_host

// >>> bsf_pkg.sv
// bsf_pkg: constants and carrier types for the boot-sector flash host controller
// assumes a 100 MHz clk and an asynchronous nor flash on plain pins
package bsf_pkg;
  localparam int BSF_ADDR_W = 18;
  localparam int BSF_DATA_W = 16;
  localparam int BSF_BYTES = 524288;
  localparam int BSF_WORDS = 262144;
  localparam int BSF_CLK_MHZ = 100;
  localparam int BSF_STROBE_NS = 70;
  localparam int BSF_STROBE_CYC = (BSF_STROBE_NS * BSF_CLK_MHZ + 999) / 1000;
  localparam logic [3:0] BSF_STROBE_CNT = 4'(BSF_STROBE_CYC);
  localparam logic [15:0] BSF_UNLOCK1_ADDR = 16'h0555;
  localparam logic [15:0] BSF_UNLOCK2_ADDR = 16'h02aa;
  localparam logic [15:0] BSF_UNLOCK1_DATA = 16'h00aa;
  localparam logic [15:0] BSF_UNLOCK2_DATA = 16'h0055;
  localparam logic [15:0] BSF_CMD_PROG = 16'h00a0;
  localparam logic [15:0] BSF_CMD_ERASE = 16'h0080;
  localparam logic [15:0] BSF_CMD_CHIP = 16'h0010;
  localparam logic [15:0] BSF_CMD_SECTOR = 16'h0030;
  localparam logic [15:0] BSF_CMD_BYPASS = 16'h0020;
  localparam logic [15:0] BSF_CMD_BYPASS_EXIT1 = 16'h0090;
  localparam logic [15:0] BSF_CMD_BYPASS_EXIT2 = 16'h0000;
  localparam logic [15:0] BSF_CMD_PAUSE = 16'h00b0;
  localparam logic [15:0] BSF_CMD_RESUME = 16'h0030;
  localparam logic [15:0] BSF_CMD_RESET = 16'h00f0;
  localparam int BSF_POLL_BIT = 7;
  localparam int BSF_TOGGLE_BIT = 6;
  localparam logic [3:0] BSF_OP_READ = 4'h0;
  localparam logic [3:0] BSF_OP_PROG = 4'h1;
  localparam logic [3:0] BSF_OP_CHIP_ERASE = 4'h2;
  localparam logic [3:0] BSF_OP_SECT_ERASE = 4'h3;
  localparam logic [3:0] BSF_OP_BYPASS_ENTER = 4'h4;
  localparam logic [3:0] BSF_OP_BYPASS_EXIT = 4'h5;
  localparam logic [3:0] BSF_OP_PAUSE = 4'h6;
  localparam logic [3:0] BSF_OP_RESUME = 4'h7;
  localparam logic [3:0] BSF_OP_RESET = 4'h8;
  localparam logic [3:0] BSF_OP_RAW = 4'h9;

  typedef struct packed {
    logic [3:0] op;
    logic [BSF_ADDR_W-1:0] addr;
    logic [BSF_DATA_W-1:0] data;
  } bsf_req_t;

  typedef struct packed {
    logic [BSF_ADDR_W-1:0] addr;
    logic [BSF_DATA_W-1:0] dout;
    logic [BSF_DATA_W-1:0] doe;
    logic chip_sel_n;
    logic write_strobe_n;
    logic out_strobe_n;
    logic restart_n;
    logic byte_mode_n;
  } bsf_pins_t;

  typedef struct packed {
    logic busy;
    logic done;
    logic timed_out;
    logic [BSF_DATA_W-1:0] rdata;
  } bsf_rsp_t;
endpackage : bsf_pkg

// >>> bsf_host_chk.sv
// bsf_host_chk: port assertions for the flash host controller
// assumes it is bound to bsf_host and sees only its ports
`timescale 1ns/1ns
module bsf_host_chk import bsf_pkg::*; (
  input wire logic clk,
  input wire logic resetn,
  input wire bsf_req_t req,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic word_mode,
  input wire logic abort,
  input wire bsf_rsp_t rsp,
  input wire bsf_pins_t pins
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_no_contention: assert property (!pins.out_strobe_n |-> pins.write_strobe_n && pins.doe == '0)
    else $error("bus driven during read");
  a_we_width: assert property (disable iff (!resetn || abort)
    $fell(pins.write_strobe_n) |-> !pins.write_strobe_n [*7] ##1 pins.write_strobe_n)
    else $error("write strobe width wrong");
  a_we_select: assert property (!pins.write_strobe_n |-> !pins.chip_sel_n)
    else $error("write strobe without select");
  a_byte_upper: assert property (!word_mode && !$past(word_mode) |-> pins.doe[15:8] == 8'h00)
    else $error("upper lines driven in byte mode");
  a_abort_restart: assert property (abort |=> !pins.restart_n)
    else $error("abort did not restart device");
  a_refuse_busy: assert property (rsp.busy |-> !req_ready)
    else $error("ready while busy");
  a_done_pulse: assert property (rsp.done |=> !rsp.done)
    else $error("done longer than one cycle");
  a_read_time: assert property (req_valid && req_ready && req.op == BSF_OP_READ && !abort |-> ##10 rsp.done)
    else $error("read answer late");
  a_busy_on_take: assert property (req_valid && req_ready && !abort |=> rsp.busy)
    else $error("busy not raised");
  a_idle_deselect: assert property (req_ready && $past(req_ready) |-> pins.chip_sel_n)
    else $error("chip selected while idle");
  c_read: cover property (req_valid && req_ready && req.op == BSF_OP_READ);
  c_abort: cover property (abort && rsp.busy);
  c_byte: cover property (!word_mode && rsp.done);
endmodule : bsf_host_chk
bind bsf_host bsf_host_chk u_chk (.clk(clk), .resetn(resetn), .req(req), .req_valid(req_valid),
  .req_ready(req_ready), .word_mode(word_mode), .abort(abort), .rsp(rsp), .pins(pins));

// >>> bsf_flash_model.sv
// bsf_flash_model: behavioural flash device on the controller's pins
// assumes word addressing, eleven sectors and a fixed busy span
`timescale 1ns/1ns
module bsf_flash_model import bsf_pkg::*; #(
  parameter int BUSY_NS = 2000,
  parameter bit BOOT_TOP = 1'b0,
  parameter logic [10:0] PROT_MASK = 11'h000,
  parameter bit UNPROT = 1'b0,
  parameter bit LOW_SUPPLY = 1'b0
) (
  input wire bsf_pins_t pins,
  output logic [BSF_DATA_W-1:0] data_lines,
  output logic ready_busy_n
);
  logic [15:0] mem [0:262143];
  logic [15:0] d, v, pdat;
  logic byp = 0, pend = 0, tog = 0, paused = 0;
  int st = 0;
  initial begin
    ready_busy_n = 1;
    for (int i = 0; i < 262144; i++) mem[i] = 16'hffff;
  end
  task automatic busy;
    ready_busy_n <= 0;
    ready_busy_n <= #BUSY_NS 1;
  endtask : busy
  // sector of a word address: 8k, 4k, 4k and 16k boot sectors, then seven of 32k
  function automatic int sect(input logic [17:0] a);
    logic [17:0] x;
    x = BOOT_TOP ? ~a : a;
    if (x >= 18'h08000) return 3 + int'(x[17:15]);
    if (x >= 18'h04000) return 3;
    if (x >= 18'h03000) return 2;
    if (x >= 18'h02000) return 1;
    return 0;
  endfunction : sect
  function automatic bit locked(input logic [17:0] a);
    return PROT_MASK[sect(a)] && !UNPROT;
  endfunction : locked
  // a negative sector number erases every unlocked sector
  task automatic ers(input int s);
    for (int i = 0; i < 262144; i++) begin
      if ((s < 0 || sect(18'(i)) == s) && !locked(18'(i))) mem[i] = 16'hffff;
    end
  endtask : ers
  // reads answer at once; automatic sleep has no visible effect here
  always_comb begin
    v = ready_busy_n ? mem[pins.addr] : {8'h00, ~pdat[7], tog, 6'h00};
    data_lines = (!pins.chip_sel_n && !pins.out_strobe_n) ? v : ~v;
    if (!pins.byte_mode_n) data_lines[15:8] = ~v[15:8];
  end
  always @(negedge pins.out_strobe_n) if (!ready_busy_n) tog = ~tog;
  always @(negedge pins.restart_n) begin
    st = 0;
    pend = 0;
    byp = 0;
    ready_busy_n <= 1;
  end
  always @(posedge pins.write_strobe_n) if (!pins.chip_sel_n && pins.restart_n && !LOW_SUPPLY) begin
    d = pins.byte_mode_n ? pins.dout : {8'h00, pins.dout[7:0]};
    if (d == BSF_CMD_RESET) st = 0;
    else if (pend) begin
      if (!locked(pins.addr)) mem[pins.addr] = mem[pins.addr] & d;
      pend = 0;
      pdat = d;
      busy();
    end else if (d == BSF_CMD_PAUSE) paused = 1;
    else if (paused && d == BSF_CMD_RESUME) paused = 0;
    else if (byp && st == 0) begin
      pend = (d == BSF_CMD_PROG);
      st = (d == BSF_CMD_BYPASS_EXIT1) ? 9 : 0;
    end else if (st == 9) begin
      byp = 0;
      st = 0;
    end else if (st == 0 || st == 3) st = (pins.addr[15:0] == BSF_UNLOCK1_ADDR && d == BSF_UNLOCK1_DATA) ? st + 1 : 0;
    else if (st == 1 || st == 4) st = (pins.addr[15:0] == BSF_UNLOCK2_ADDR && d == BSF_UNLOCK2_DATA) ? st + 1 : 0;
    else if (st == 2) begin
      pend = (d == BSF_CMD_PROG);
      byp = (d == BSF_CMD_BYPASS);
      st = (d == BSF_CMD_ERASE) ? 3 : 0;
    end else begin
      st = 0;
      pdat = 16'hffff;
      if (d == BSF_CMD_CHIP) ers(-1);
      else if (d == BSF_CMD_SECTOR) ers(sect(pins.addr));
      busy();
    end
  end
endmodule : bsf_flash_model

// >>> bsf_host_tb.sv
// bsf_host_tb: directed tests of the flash host controller
// assumes the flash model on its pins and a 100 MHz clock
`timescale 1ns/1ns
module bsf_host_tb import bsf_pkg::*;;
  logic clk = 0, resetn = 0, req_valid = 0, word_mode = 1, abort = 0, req_ready, rbn;
  bsf_req_t req = '0;
  bsf_rsp_t rsp;
  bsf_pins_t pins;
  logic [15:0] dl;
  int bad_count = 0, total_checks = 0;
  always #5 clk = ~clk;
  bsf_host #(.TIMEOUT_CYC(3000)) u_dut (.clk(clk), .resetn(resetn), .req(req), .req_valid(req_valid),
    .req_ready(req_ready), .word_mode(word_mode), .abort(abort), .rsp(rsp), .pins(pins),
    .data_lines_in(dl), .ready_busy_n(rbn));
  bsf_flash_model #(.PROT_MASK(11'h400)) u_dev (.pins(pins), .data_lines(dl), .ready_busy_n(rbn));
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task start(input logic [3:0] o, input logic [17:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(negedge clk);
    req <= '{op: o, addr: a, data: d};
    req_valid <= 1;
    while (req_ready !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    req_valid <= 0;
  endtask : start
  task fin;
    int n;
    n = 0;
    while (rsp.done !== 1'b1 && n < 5000) begin
      @(negedge clk);
      n++;
    end
    chk(16'(n < 5000), 16'h0001);
    chk({15'h0000, rsp.timed_out}, 16'h0000);
  endtask : fin
  task op(input logic [3:0] o, input logic [17:0] a, input logic [15:0] d);
    start(o, a, d);
    fin();
  endtask : op
  task rd(input logic [17:0] a, input logic [15:0] e);
    op(BSF_OP_READ, a, 16'h0000);
    chk(rsp.rdata, e);
  endtask : rd
  task end_sim;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  initial begin
    #200000;
    bad_count++;
    $display("[ERR] %0t watchdog expired", $time);
    end_sim();
  end
  initial begin
    repeat (12) @(negedge clk);
    resetn <= 1;
    repeat (3) @(negedge clk);
    rd(18'h00100, 16'hffff);
    op(BSF_OP_PROG, 18'h00100, 16'h1234);
    rd(18'h00100, 16'h1234);
    op(BSF_OP_PROG, 18'h00100, 16'h00ff);
    rd(18'h00100, 16'h0034);
    op(BSF_OP_PROG, 18'h38000, 16'h0000);
    rd(18'h38000, 16'hffff);
    $display("test program done");
    op(BSF_OP_BYPASS_ENTER, 18'h00000, 16'h0000);
    op(BSF_OP_PROG, 18'h08000, 16'h5a5a);
    op(BSF_OP_BYPASS_EXIT, 18'h00000, 16'h0000);
    rd(18'h08000, 16'h5a5a);
    op(BSF_OP_SECT_ERASE, 18'h08000, 16'h0000);
    rd(18'h08000, 16'hffff);
    rd(18'h00100, 16'h0034);
    word_mode <= 0;
    rd(18'h00100, 16'h0034);
    word_mode <= 1;
    $display("test bypass and sector erase done");
    op(BSF_OP_PAUSE, 18'h00000, 16'h0000);
    op(BSF_OP_RESUME, 18'h00000, 16'h0000);
    op(BSF_OP_RESET, 18'h00000, 16'h0000);
    op(BSF_OP_RAW, 18'h00555, BSF_CMD_RESET);
    op(BSF_OP_CHIP_ERASE, 18'h00000, 16'h0000);
    rd(18'h00100, 16'hffff);
    $display("test chip erase done");
    start(BSF_OP_CHIP_ERASE, 18'h00000, 16'h0000);
    repeat (100) @(negedge clk);
    abort <= 1;
    repeat (2) @(negedge clk);
    chk({15'h0000, pins.restart_n}, 16'h0000);
    abort <= 0;
    repeat (3) @(negedge clk);
    op(BSF_OP_PROG, 18'h00200, 16'ha5a5);
    rd(18'h00200, 16'ha5a5);
    $display("test abort done");
    end_sim();
  end
endmodule : bsf_host_tb
